// ---- iwt_pkg.sv ----
// Package of constants and types for the image window trigger
package iwt_pkg;

  // ****************************************************************
  // Window geometry
  // ****************************************************************
  localparam int unsigned  SIZE_X_MIN   = 4;
  localparam int unsigned  SIZE_X_MAX   = 32;
  localparam int unsigned  SIZE_Y_MIN   = 4;
  localparam int unsigned  SIZE_Y_MAX   = 64;
  localparam int unsigned  COORD_W      = 10;
  localparam int unsigned  PIX_W        = 8;
  localparam int unsigned  CNT_W        = 12;
  localparam int unsigned  SUM_W        = 20;
  localparam int unsigned  NUM_TYPES    = 16;
  localparam int unsigned  TYPE_W       = 4;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0]   ERR_NOT_SET  = 8'h22;
  localparam logic [7:0]   ERR_NONE     = 8'h00;
  localparam logic [7:0]   LIMIT_UP_RST = 8'hff;
  localparam logic [7:0]   LIMIT_LO_RST = 8'h00;
  localparam logic [COORD_W-1:0] POS_RST = 10'h000;

  // Settling time between windows, figure used for cycle estimates
  localparam int unsigned  CLK_HZ       = 20000000;
  localparam int unsigned  REARM_NS     = 1000;
  localparam int unsigned  REARM_CYC    = (REARM_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {IWT_BINARY, IWT_MEAN} iwt_method_t;
  typedef enum logic {IWT_START_PARALLEL, IWT_START_AUTO} iwt_start_t;

  typedef struct packed {
    logic                valid;
    logic                frame_start;
    logic [COORD_W-1:0]  x;
    logic [COORD_W-1:0]  y;
    logic [PIX_W-1:0]    data;
  } iwt_pixel_t;

  typedef struct packed {
    logic [COORD_W-1:0]  x;
    logic [COORD_W-1:0]  y;
  } iwt_pos_t;

  typedef struct packed {
    logic [5:0]          size_x;
    logic [6:0]          size_y;
    logic [PIX_W-1:0]    upper_intensity_limit;
    logic [PIX_W-1:0]    lower_intensity_limit;
    iwt_method_t         method;
    logic                invert;
  } iwt_cfg_t;

endpackage

// ---- iwt_pos_mem.sv ----
// Per object type window position store with registered read
`timescale 1ns/1ps
`default_nettype none
module iwt_pos_mem (
  input  wire logic                     clk_sys,
  input  wire logic                     wr_en,
  input  wire logic [iwt_pkg::TYPE_W-1:0] wr_type,
  input  wire iwt_pkg::iwt_pos_t        wr_pos,
  input  wire logic [iwt_pkg::TYPE_W-1:0] rd_type,
  output iwt_pkg::iwt_pos_t             rd_pos
);
  iwt_pkg::iwt_pos_t mem [iwt_pkg::NUM_TYPES];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_type] <= wr_pos;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_pos <= mem[rd_type];
  end
endmodule
`default_nettype wire

// ---- iwt_top.sv ----
// Image window trigger: samples a camera window and fires a measurement start
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - While sampling, capture window every frame and start measurement on change.
// - Binary mode fires when white pixels exceed half the window area.
// - Without inversion, fire on black background turning to white content.
// - With inversion, fire on white background turning to black content.
// - Mean mode fires when window mean lies within lower..upper limits.
// - Window size accepted only 4..32 by 4..64 pixels.
// - Upper and lower limits each independently settable 0..255.
// - Window of any size is sampled once per camera frame, so size does not change the sampling cycle.
// - Separate window position per object type, applied on type change.
// - Only first camera feeds the trigger, second never does.
// - Parallel start: sample only while start input held on.
// - After measurement, resume on start input off-to-on edge (parallel start) or on auto_start (auto start).
// - Trigger selected with missing window settings reports error 34.
module iwt_top (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire iwt_pkg::iwt_pixel_t        cam1_pixel,
  input  wire iwt_pkg::iwt_pixel_t        cam2_pixel,
  input  wire iwt_pkg::iwt_cfg_t          trigger_window_settings,
  input  wire logic                       settings_valid,
  input  wire logic                       trigger_method_select,
  input  wire iwt_pkg::iwt_start_t        start_mode,
  input  wire logic                       sampling_start_input,
  input  wire logic                       auto_start,
  input  wire logic                       meas_done,
  input  wire logic [iwt_pkg::TYPE_W-1:0] object_type,
  input  wire logic                       pos_wr_en,
  input  wire logic [iwt_pkg::TYPE_W-1:0] pos_wr_type,
  input  wire iwt_pkg::iwt_pos_t          pos_wr,
  output logic                            meas_start,
  output logic                            sampling,
  output logic                            size_error,
  output logic [7:0]                      error_code
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic start_meta;
  logic start_sync;
  logic start_prev;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      start_meta <= sampling_start_input;
      start_sync <= start_meta;
      start_prev <= start_sync;
    end
  end
  wire start_rise = start_sync & ~start_prev;

  // ****************************************************************
  // Window configuration
  // ****************************************************************
  iwt_pkg::iwt_pos_t win_pos;
  logic [iwt_pkg::TYPE_W-1:0] type_prev;
  logic                       pos_ready;

  iwt_pos_mem u_pos_mem (
    .clk_sys (clk_sys),
    .wr_en   (pos_wr_en),
    .wr_type (pos_wr_type),
    .wr_pos  (pos_wr),
    .rd_type (object_type),
    .rd_pos  (win_pos)
  );

  // Hold sampling one cycle after a type change so new position applies
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      type_prev <= '0;
      pos_ready <= 1'b0;
    end else begin
      type_prev <= object_type;
      pos_ready <= (object_type == type_prev);
    end
  end

  iwt_pkg::iwt_cfg_t cfg;
  assign cfg = trigger_window_settings;

  wire size_ok = (cfg.size_x >= 6'(iwt_pkg::SIZE_X_MIN)) &&
                 (cfg.size_x <= 6'(iwt_pkg::SIZE_X_MAX)) &&
                 (cfg.size_y >= 7'(iwt_pkg::SIZE_Y_MIN)) &&
                 (cfg.size_y <= 7'(iwt_pkg::SIZE_Y_MAX));
  wire cfg_ok  = settings_valid & size_ok;

  // ****************************************************************
  // Error reporting
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_code <= iwt_pkg::ERR_NONE;
      size_error <= 1'b0;
    end else begin
      size_error <= settings_valid & ~size_ok;
      if (trigger_method_select && !cfg_ok) begin
        error_code <= iwt_pkg::ERR_NOT_SET;
      end else begin
        error_code <= iwt_pkg::ERR_NONE;
      end
    end
  end

  // ****************************************************************
  // Sampling control
  // ****************************************************************
  typedef enum logic [1:0] {IWT_IDLE, IWT_SAMPLE, IWT_WAIT_DONE} iwt_state_t;
  iwt_state_t state;
  logic       fire;
  wire        enable_ok = trigger_method_select & cfg_ok;
  wire        hold_ok   = (start_mode == iwt_pkg::IWT_START_AUTO) ? 1'b1 : start_sync;
  wire        arm_req   = (start_mode == iwt_pkg::IWT_START_AUTO) ? auto_start : start_rise;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= IWT_IDLE;
    end else begin
      case (state)
        IWT_IDLE: begin
          if (enable_ok && arm_req) begin
            state <= IWT_SAMPLE;
          end
        end
        IWT_SAMPLE: begin
          if (!enable_ok || !hold_ok) begin
            state <= IWT_IDLE;
          end else if (fire) begin
            state <= IWT_WAIT_DONE;
          end
        end
        IWT_WAIT_DONE: begin
          if (meas_done) begin
            state <= IWT_IDLE;
          end
        end
        default: state <= IWT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sampling <= 1'b0;
    end else begin
      sampling <= (state == IWT_SAMPLE);
    end
  end

  // ****************************************************************
  // Window accumulation, camera 1 only
  // ****************************************************************
  iwt_pkg::iwt_pixel_t px;
  assign px = cam1_pixel;

  logic [iwt_pkg::CNT_W-1:0] white_cnt;
  logic [iwt_pkg::CNT_W-1:0] pix_cnt;
  logic [iwt_pkg::SUM_W-1:0] int_sum;
  logic                      active;

  wire in_x = (px.x >= win_pos.x) &&
              ({1'b0, px.x} < {1'b0, win_pos.x} + 11'(cfg.size_x));
  wire in_y = (px.y >= win_pos.y) &&
              ({1'b0, px.y} < {1'b0, win_pos.y} + 11'(cfg.size_y));
  wire in_win = px.valid & in_x & in_y;
  wire is_white = (px.data >= cfg.lower_intensity_limit) &&
                  (px.data <= cfg.upper_intensity_limit);
  wire [iwt_pkg::CNT_W-1:0] area = iwt_pkg::CNT_W'(cfg.size_x) * iwt_pkg::CNT_W'(cfg.size_y);
  wire last_pix = in_win && (pix_cnt + 1'b1 == area);
  wire run = (state == IWT_SAMPLE) & pos_ready & hold_ok;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      white_cnt <= '0;
      pix_cnt   <= '0;
      int_sum   <= '0;
      active    <= 1'b0;
    end else if (!run) begin
      white_cnt <= '0;
      pix_cnt   <= '0;
      int_sum   <= '0;
      active    <= 1'b0;
    end else if (px.frame_start) begin
      // First pixel of a frame may already lie inside the window
      white_cnt <= (in_win && is_white) ? iwt_pkg::CNT_W'(1) : '0;
      pix_cnt   <= in_win ? iwt_pkg::CNT_W'(1) : '0;
      int_sum   <= in_win ? iwt_pkg::SUM_W'(px.data) : '0;
      active    <= 1'b1;
    end else if (active && in_win) begin
      white_cnt <= white_cnt + iwt_pkg::CNT_W'(is_white);
      pix_cnt   <= pix_cnt + 1'b1;
      int_sum   <= int_sum + iwt_pkg::SUM_W'(px.data);
      if (last_pix) begin
        active <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Evaluation and trigger decision
  // ****************************************************************
  wire [iwt_pkg::CNT_W-1:0] white_fin = white_cnt + iwt_pkg::CNT_W'(is_white);
  wire [iwt_pkg::SUM_W-1:0] sum_fin   = int_sum + iwt_pkg::SUM_W'(px.data);
  wire [iwt_pkg::CNT_W-1:0] white_eff = cfg.invert ? (area - white_fin) : white_fin;
  wire over_half = ({white_eff, 1'b0} > {1'b0, area});
  wire [iwt_pkg::SUM_W+iwt_pkg::CNT_W-1:0] lo_prod =
    (iwt_pkg::SUM_W+iwt_pkg::CNT_W)'(cfg.lower_intensity_limit) * area;
  wire [iwt_pkg::SUM_W+iwt_pkg::CNT_W-1:0] up_prod =
    (iwt_pkg::SUM_W+iwt_pkg::CNT_W)'(cfg.upper_intensity_limit) * area;
  wire [iwt_pkg::SUM_W+iwt_pkg::CNT_W-1:0] sum_ext =
    (iwt_pkg::SUM_W+iwt_pkg::CNT_W)'(sum_fin);
  wire in_range = (sum_ext >= lo_prod) && (sum_ext <= up_prod);
  wire cond = (cfg.method == iwt_pkg::IWT_BINARY) ? over_half : in_range;

  // Background must be seen first so only a change fires
  logic bg_seen;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bg_seen <= 1'b0;
      fire    <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (state != IWT_SAMPLE) begin
        bg_seen <= 1'b0;
      end else if (run && active && !px.frame_start && last_pix) begin
        if (!cond) begin
          bg_seen <= 1'b1;
        end else if (bg_seen) begin
          fire <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= fire & (state == IWT_SAMPLE);
    end
  end

  // Second camera deliberately unused
  wire unused_cam2 = ^cam2_pixel;
endmodule
`default_nettype wire

// ---- iwt_cam.sv ----
// Camera model: 8x8 raster frames, bright quadrant and surround levels
`timescale 1ns/1ps
`default_nettype none
module iwt_cam (
  input  wire logic               clk_sys,
  input  wire logic [7:0]         lvl_in,
  input  wire logic [7:0]         lvl_out,
  output var iwt_pkg::iwt_pixel_t pix
);
  logic [6:0] n = 7'h00;
  logic [7:0] li;
  logic [7:0] lo;
  // Levels latched in the idle slot so each frame is uniform
  always_ff @(posedge clk_sys) begin
    n <= (n == 7'h40) ? 7'h00 : n + 7'h01;
    if (n == 7'h40) begin
      li <= lvl_in;
      lo <= lvl_out;
    end
  end
  // Idle slot between frames carries the inverted bright level
  always_comb begin
    pix.valid       = (n != 7'h40);
    pix.frame_start = (n == 7'h00);
    pix.x           = {7'h00, n[2:0]};
    pix.y           = {7'h00, n[5:3]};
    pix.data        = !pix.valid ? ~li : (n[2] && n[5]) ? li : lo;
  end
endmodule
`default_nettype wire

// ---- iwt_top_properties.sv ----
// Port checker for the image window trigger
`timescale 1ns/1ps
`default_nettype none
module iwt_top_properties (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire iwt_pkg::iwt_cfg_t   trigger_window_settings,
  input wire logic                settings_valid,
  input wire logic                trigger_method_select,
  input wire iwt_pkg::iwt_start_t start_mode,
  input wire logic                sampling_start_input,
  input wire logic                meas_start,
  input wire logic                sampling,
  input wire logic                size_error,
  input wire logic [7:0]          error_code
);
  wire logic [5:0] sx = trigger_window_settings.size_x;
  wire logic [6:0] sy = trigger_window_settings.size_y;
  wire logic       bad = sx < 6'h04 || sx > 6'h20 || sy < 7'h04 || sy > 7'h40;
  wire logic       par = start_mode == iwt_pkg::IWT_START_PARALLEL;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  start_pulse_a: assert property (meas_start |=> !meas_start)
    else $error("start pulse too long");
  fire_sampling_a: assert property (meas_start |-> $past(sampling))
    else $error("start outside sampling");
  fire_stop_a: assert property (meas_start |-> ##[0:3] !sampling)
    else $error("sampling kept after start");
  release_stop_a: assert property (par && !sampling_start_input [*4] |-> ##[0:4] !sampling)
    else $error("sampling kept after release");
  rise_cause_a: assert property ($rose(sampling) && par |-> $past(sampling_start_input, 2))
    else $error("sampling without start input");
  err_set_a: assert property (trigger_method_select && (!settings_valid || bad)
    |=> error_code == 8'h22) else $error("error code missing");
  err_clear_a: assert property (!trigger_method_select |=> error_code == 8'h00)
    else $error("error code without trigger");
  size_bad_a: assert property (settings_valid && bad |=> size_error)
    else $error("size error missing");
  size_ok_a: assert property (settings_valid && !bad |=> !size_error)
    else $error("size error on legal size");
  cover property (meas_start);
  cover property ($rose(sampling));
  cover property (size_error && error_code == 8'h22);
endmodule
bind iwt_top iwt_top_properties chk (.clk_sys, .rst_n, .trigger_window_settings, .settings_valid,
  .trigger_method_select, .start_mode, .sampling_start_input, .meas_start, .sampling, .size_error,
  .error_code);
`default_nettype wire

// ---- iwt_top_tb.sv ----
// Self-checking testbench for the image window trigger
`timescale 1ns/1ps
`default_nettype none
module iwt_top_tb;
  logic                clk_sys, rst_n, settings_valid, trigger_method_select;
  logic                sampling_start_input, auto_start, meas_done, pos_wr_en;
  logic                meas_start, sampling, size_error;
  logic [7:0]          error_code, lvl, lvl_o;
  logic [3:0]          object_type, pos_wr_type;
  iwt_pkg::iwt_pixel_t cam1_pixel, cam2_pixel;
  iwt_pkg::iwt_cfg_t   trigger_window_settings;
  iwt_pkg::iwt_start_t start_mode;
  iwt_pkg::iwt_pos_t   pos_wr;
  int                  mismatches, tests_run, fires;
  iwt_cam cam_a (.clk_sys, .lvl_in(lvl), .lvl_out(lvl_o), .pix(cam1_pixel));
  iwt_cam cam_b (.clk_sys, .lvl_in(~lvl), .lvl_out(~lvl_o), .pix(cam2_pixel));
  iwt_top DUT (.clk_sys, .rst_n, .cam1_pixel, .cam2_pixel, .trigger_window_settings,
    .settings_valid, .trigger_method_select, .start_mode, .sampling_start_input, .auto_start,
    .meas_done, .object_type, .pos_wr_en, .pos_wr_type, .pos_wr, .meas_start, .sampling,
    .size_error, .error_code);
  // ********
  // Helpers
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (meas_start === 1'b1) fires <= fires + 1;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic hit(input logic m, inv, input logic [7:0] lo, up, v);
    logic in = v >= lo && v <= up;
    return m ? in : inv ^ in;
  endfunction
  task automatic trial(input logic [3:0] ty, input logic m, inv,
                       input logic [7:0] lo, up, b, a, o, input logic e);
    object_type <= ty;
    trigger_window_settings.method <= iwt_pkg::iwt_method_t'(m);
    trigger_window_settings.invert <= inv;
    trigger_window_settings.upper_intensity_limit <= up;
    trigger_window_settings.lower_intensity_limit <= lo;
    lvl <= b;
    lvl_o <= b;
    fires = 0;
    cyc(140);
    if (start_mode == iwt_pkg::IWT_START_AUTO) auto_start <= 1'b1;
    else sampling_start_input <= 1'b1;
    cyc(1);
    auto_start <= 1'b0;
    cyc(200);
    check("sampling", {7'h00, sampling}, 8'h01);
    lvl <= a;
    lvl_o <= o;
    cyc(300);
    check("fires", fires[7:0], {7'h00, e});
    meas_done <= 1'b1;
    cyc(1);
    meas_done <= 1'b0;
    cyc(20);
    check("sampling after done", {7'h00, sampling}, {7'h00, !e});
    sampling_start_input <= 1'b0;
    cyc(8);
    if (start_mode == iwt_pkg::IWT_START_PARALLEL)
      check("sampling released", {7'h00, sampling}, 8'h00);
  endtask
  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    int cx[4] = '{3, 4, 32, 33};
    int cy[4] = '{3, 4, 64, 65};
    int sx, sy;
    logic v, tm, bad, m, inv;
    logic [7:0] lo, up, b, a;
    {rst_n, settings_valid, trigger_method_select, sampling_start_input} = '0;
    {auto_start, meas_done, pos_wr_en, lvl, lvl_o, object_type, pos_wr_type, pos_wr} = '0;
    start_mode = iwt_pkg::IWT_START_PARALLEL;
    trigger_window_settings = '{6'h04, 7'h04, 8'hff, 8'h64, iwt_pkg::IWT_BINARY, 1'b0};
    {mismatches, tests_run, fires} = '0;
    void'($urandom(32'h3fb17a58));
    cyc(16);
    rst_n <= 1'b1;
    // Window size and error reporting, corners then random
    for (int i = 0; i < 26; i++) begin
      sx = i < 16 ? cx[i % 4] : $urandom_range(2, 34);
      sy = i < 16 ? cy[i / 4] : $urandom_range(2, 66);
      v = i < 16 || $urandom_range(0, 1) == 1;
      tm = i < 16 || $urandom_range(0, 1) == 1;
      trigger_window_settings.size_x <= sx[5:0];
      trigger_window_settings.size_y <= sy[6:0];
      settings_valid <= v;
      trigger_method_select <= tm;
      cyc(3);
      bad = sx < 4 || sx > 32 || sy < 4 || sy > 64;
      check("size_error", {7'h00, size_error}, {7'h00, v && bad});
      check("error_code", error_code, tm && (!v || bad) ? 8'h22 : 8'h00);
    end
    trigger_window_settings.size_x <= 6'h04;
    trigger_window_settings.size_y <= 7'h04;
    settings_valid <= 1'b1;
    trigger_method_select <= 1'b1;
    // Window per type: 0 dark corner, 1 in quadrant, 2 half, 3 three quarters
    for (int t = 0; t < 4; t++) begin
      pos_wr_en <= 1'b1;
      pos_wr_type <= 4'(t);
      pos_wr <= '{10'(t == 1 ? 4 : t), 10'(t == 0 ? 0 : 4)};
      cyc(1);
    end
    pos_wr_en <= 1'b0;
    trial(4'h1, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'hc8, 8'hc8, 1'b1);
    trial(4'h1, 1'b0, 1'b0, 8'h64, 8'hff, 8'hc8, 8'h00, 8'h00, 1'b0);
    trial(4'h1, 1'b0, 1'b1, 8'h64, 8'hff, 8'hc8, 8'h00, 8'h00, 1'b1);
    trial(4'h1, 1'b1, 1'b0, 8'h64, 8'h96, 8'h32, 8'h96, 8'h96, 1'b1);
    trial(4'h1, 1'b1, 1'b0, 8'h64, 8'h96, 8'h32, 8'h97, 8'h97, 1'b0);
    trial(4'h1, 1'b1, 1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 1'b1);
    trial(4'h0, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'hc8, 8'h00, 1'b0);
    trial(4'h0, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'h00, 8'hc8, 1'b1);
    trial(4'h2, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'hc8, 8'h00, 1'b0);
    trial(4'h3, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'hc8, 8'h00, 1'b1);
    for (int i = 0; i < 12; i++) begin
      m = $urandom_range(0, 1) == 1;
      inv = $urandom_range(0, 1) == 1;
      lo = 8'($urandom_range(0, 200));
      up = lo + 8'($urandom_range(0, 55));
      b = 8'($urandom);
      a = i[0] ? lo : up;
      trial(4'h1, m, inv, lo, up, b, a, a, !hit(m, inv, lo, up, b) && hit(m, inv, lo, up, a));
    end
    start_mode <= iwt_pkg::IWT_START_AUTO;
    trial(4'h1, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'hc8, 8'hc8, 1'b1);
    trial(4'h3, 1'b0, 1'b0, 8'h64, 8'hff, 8'h00, 8'hc8, 8'h00, 1'b1);
    test_done();
  end
  initial begin
    #(50 * 40000);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
